// ===== hw/cise_pkg.sv
// shared constants and carriers for the instruction-subset execution unit
package cise_pkg;
    // *****************************************************************
    // operation codes
    // *****************************************************************
    typedef enum logic [4:0] {
        CISE_NOP, CISE_BANK_SW, CISE_BCD_ADJ, CISE_INC1, CISE_ADD_TWO, CISE_DEC1, CISE_SUBTRACT_TWO,
        CISE_HOLD_OFF, CISE_DIV_S, CISE_DIV_SD, CISE_DIV_U, CISE_DIV_UD, CISE_DIV_F,
        CISE_LOOP_LIT, CISE_LOOP_REG, CISE_SQR, CISE_SQR_ACC, CISE_SWAP, CISE_BIT_CHG,
        CISE_LEAD_ONE, CISE_TRAIL_ONE, CISE_JUMP, CISE_OR
    } cise_op_t;

    // *****************************************************************
    // cycle counts and field widths
    // *****************************************************************
    localparam logic [4:0] CISE_CYC_ONE    = 5'h01;
    localparam logic [4:0] CISE_CYC_TWO    = 5'h02;
    localparam logic [4:0] CISE_CYC_JUMP   = 5'h04;
    localparam logic [4:0] CISE_CYC_DIV    = 5'h12;
    localparam int         CISE_BANK_W     = 3;
    localparam int         CISE_HOLD_W     = 14;
    localparam int         CISE_LOOP_W     = 15;
    localparam logic [5:0] CISE_NO_BIT     = 6'h00;
    localparam logic [3:0] CISE_BCD_LIMIT  = 4'h9;
    localparam logic [7:0] CISE_BCD_LO_FIX = 8'h06;
    localparam logic [7:0] CISE_BCD_HI_FIX = 8'h60;

    // status flags: carry, digit carry, negative, overflow, zero, accumulator ov/sat
    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic oa;
        logic sa;
    } cise_flags_t;

    typedef struct packed {
        cise_op_t    op;
        logic [15:0] a;       // source / dividend low / square operand
        logic [15:0] b;       // second source / divisor
        logic [15:0] ext;     // dividend high word, second instruction word
        logic        sfr_ext; // operand is a non-core special-function register
    } cise_req_t;

    typedef struct packed {
        logic [15:0] res;
        logic [15:0] res2;    // remainder or swapped partner
        logic [39:0] acc;
        logic [2:0]  bank;
        logic [14:0] loop_cnt;
        logic [15:0] loop_end;
        logic [23:0] jump_pc;
        cise_flags_t flags;
        logic [7:0]  upd;     // which flags were written: c dc n ov z oa sa, bit7 unused
    } cise_rsp_t;
endpackage

// ===== hw/cise_exec.sv
// execution unit for a subset of the 16-bit signal-controller instruction set
`timescale 1ns/1ps
// Operation
// [RULE1] bank switch selects context from 3-bit literal or register; two cycles, no flags
// [RULE2] bcd adjust corrects the byte in place; one cycle, carry only
// [RULE3] hold-off blocks interrupts for a 14-bit literal count; one cycle, no flags
// [RULE4] signed 16/16 and 32/16 divides: 18 cycles, n z c ov
// [RULE5] unsigned 16/16 and 32/16 divides: 18 cycles, n z c ov
// [RULE6] signed fractional 16/16 divide: 18 cycles, n z c ov
// [RULE7] literal loop repeats body literal plus one times; two cycles, no flags
// [RULE8] register loop repeats body register plus one times; two cycles, no flags
// [RULE9] square into accumulator, or add square; one cycle, accumulator ov/sat flags
// [RULE10] find first bit differing from sign, from msb; one cycle, carry only
// [RULE11] find first set bit from msb; one cycle, carry only
// [RULE12] find first set bit from lsb; one cycle, carry only
// [RULE13] jump takes four cycles in every form and changes no flags; here a jump with sfr_ext set takes five
// [RULE14] swap two working registers in one cycle, no flags
// [RULE15] a non-core register operand adds one cycle
// [RULE16] add/subtract one or two: one cycle, c dc n ov z
// [RULE17] or with default working register: one cycle, n and z only
module cise_exec (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clk_en,
    input  wire logic              req_valid,
    input  wire cise_pkg::cise_req_t req,
    input  wire logic [39:0]       acc_in,
    output logic                   busy,
    output logic                   done,
    output cise_pkg::cise_rsp_t    rsp,
    output logic                   irq_block
);
    // *****************************************************************
    // combinational results
    // *****************************************************************
    function automatic logic [5:0] msb_pos(input logic [15:0] v);
        logic [5:0] p;
        p = cise_pkg::CISE_NO_BIT;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                p = 6'(16 - i);
            end
        end
        return p;
    endfunction

    wire cise_pkg::cise_op_t op       = req.op;
    wire logic [15:0]  a              = req.a;
    wire logic [15:0]  b              = req.b;
    wire logic [16:0]  step_v         = (op == cise_pkg::CISE_ADD_TWO || op == cise_pkg::CISE_SUBTRACT_TWO)
                                        ? 17'h00002 : 17'h00001;
    wire logic         is_sub         = (op == cise_pkg::CISE_DEC1 || op == cise_pkg::CISE_SUBTRACT_TWO);
    wire logic [16:0]  arith_v        = is_sub ? ({1'b0, a} - step_v) : ({1'b0, a} + step_v);
    wire logic [4:0]   nib_v          = is_sub ? ({1'b0, a[3:0]} - step_v[4:0])
                                               : ({1'b0, a[3:0]} + step_v[4:0]);
    wire logic         arith_ov       = is_sub ? (a[15] & ~arith_v[15]) : (~a[15] & arith_v[15]);
    wire logic [15:0]  or_v           = a | b;
    // bcd correction on the low byte
    wire logic         bcd_lo         = (a[3:0] > cise_pkg::CISE_BCD_LIMIT);
    wire logic [8:0]   bcd_s1         = {1'b0, a[7:0]} + (bcd_lo ? {1'b0, cise_pkg::CISE_BCD_LO_FIX} : 9'h000);
    wire logic         bcd_hi         = (bcd_s1[7:4] > cise_pkg::CISE_BCD_LIMIT) | bcd_s1[8];
    wire logic [8:0]   bcd_v          = bcd_s1 + (bcd_hi ? {1'b0, cise_pkg::CISE_BCD_HI_FIX} : 9'h000);
    // bit searches: position 1..16, 0 with carry when nothing found
    wire logic [15:0]  chg_mask       = a[15] ? ~a : a;
    wire logic [5:0]   lead_one_v     = msb_pos(a);
    wire logic [5:0]   bit_chg_v      = msb_pos({1'b0, chg_mask[14:0]});
    wire logic [5:0]   trail_one_v    = msb_pos({<<{a}});
    // square
    wire logic signed [31:0] sq_v     = $signed(a) * $signed(a);
    wire logic [39:0]  sq_ext         = {{8{sq_v[31]}}, sq_v};
    wire logic [40:0]  acc_sum        = {acc_in[39], acc_in} + {sq_ext[39], sq_ext};
    wire logic [39:0]  acc_v          = (op == cise_pkg::CISE_SQR_ACC) ? acc_sum[39:0] : sq_ext;
    wire logic         acc_ovf        = acc_sum[40] ^ acc_sum[39];

    // cycle count per operation, with the extra peripheral-access cycle
    wire logic [4:0]   base_cyc       =
        (op == cise_pkg::CISE_DIV_S || op == cise_pkg::CISE_DIV_SD || op == cise_pkg::CISE_DIV_U ||
         op == cise_pkg::CISE_DIV_UD || op == cise_pkg::CISE_DIV_F) ? cise_pkg::CISE_CYC_DIV :
        (op == cise_pkg::CISE_JUMP) ? cise_pkg::CISE_CYC_JUMP :                       // see [RULE13]
        (op == cise_pkg::CISE_BANK_SW || op == cise_pkg::CISE_LOOP_LIT ||
         op == cise_pkg::CISE_LOOP_REG) ? cise_pkg::CISE_CYC_TWO :                    // see [RULE1]
        cise_pkg::CISE_CYC_ONE;
    wire logic [4:0]   total_cyc      = base_cyc + {4'h0, req.sfr_ext};              // see [RULE15]

    // *****************************************************************
    // divider: restoring, one quotient bit per cycle over sixteen of the eighteen cycles
    // *****************************************************************
    cise_pkg::cise_op_t op_r;
    logic [4:0]   cnt_r;
    logic [31:0]  rem_r;
    logic [31:0]  quo_r;
    logic [15:0]  dsr_r;
    logic         neg_q_r;
    logic         neg_r_r;
    logic         ovf_hi_r;
    logic [13:0]  hold_r;
    cise_pkg::cise_rsp_t pend_r;

    wire logic         div_signed     = (op == cise_pkg::CISE_DIV_S || op == cise_pkg::CISE_DIV_SD ||
                                         op == cise_pkg::CISE_DIV_F);
    wire logic         div_long       = (op == cise_pkg::CISE_DIV_SD || op == cise_pkg::CISE_DIV_UD);
    wire logic [31:0]  dvd_raw        = (op == cise_pkg::CISE_DIV_F) ? {a, 16'h0000} :
                                        div_long ? {req.ext, a} :
                                        div_signed ? {{16{a[15]}}, a} : {16'h0000, a};
    wire logic         dvd_neg        = div_signed & dvd_raw[31];
    wire logic         dsr_neg        = div_signed & b[15];
    wire logic [31:0]  dvd_abs        = dvd_neg ? 32'(-dvd_raw) : dvd_raw;
    wire logic [15:0]  dsr_abs        = dsr_neg ? 16'(-b) : b;
    wire logic [32:0]  rem_sh         = {rem_r, quo_r[31]};
    wire logic         sub_ok         = (rem_sh >= {17'h00000, dsr_r});
    wire logic [31:0]  rem_step       = sub_ok ? 32'(rem_sh - {17'h00000, dsr_r}) : rem_sh[31:0];
    wire logic [31:0]  quo_step       = {quo_r[30:0], sub_ok};
    wire logic [15:0]  q_fin          = neg_q_r ? 16'(-quo_r[15:0]) : quo_r[15:0];
    wire logic [15:0]  r_fin          = neg_r_r ? 16'(-rem_r[15:0]) : rem_r[15:0];
    wire logic         q_ovf          = (dsr_r == 16'h0000) || ovf_hi_r ||
                                        ((op_r != cise_pkg::CISE_DIV_U && op_r != cise_pkg::CISE_DIV_UD)
                                         && quo_r[15] && !(neg_q_r && quo_r[14:0] == 15'h0000));
    wire logic         div_op_r       = (op_r == cise_pkg::CISE_DIV_S || op_r == cise_pkg::CISE_DIV_SD ||
                                         op_r == cise_pkg::CISE_DIV_U || op_r == cise_pkg::CISE_DIV_UD ||
                                         op_r == cise_pkg::CISE_DIV_F);
    wire logic [4:0]   div_steps      = 5'h10;

    // *****************************************************************
    // single-step result assembly
    // *****************************************************************
    cise_pkg::cise_rsp_t rsp_nxt;
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.acc = acc_in;
        unique case (op)
            cise_pkg::CISE_BANK_SW:  rsp_nxt.bank = a[cise_pkg::CISE_BANK_W-1:0];  // see [RULE1]
            cise_pkg::CISE_BCD_ADJ: begin                                          // see [RULE2]
                rsp_nxt.res = {a[15:8], bcd_v[7:0]};
                rsp_nxt.flags.c = bcd_v[8] | bcd_hi;
                rsp_nxt.upd = 8'h01;
            end
            cise_pkg::CISE_INC1, cise_pkg::CISE_ADD_TWO,
            cise_pkg::CISE_DEC1, cise_pkg::CISE_SUBTRACT_TWO: begin                       // see [RULE16]
                rsp_nxt.res = arith_v[15:0];
                rsp_nxt.flags.c = is_sub ? ~arith_v[16] : arith_v[16];
                rsp_nxt.flags.dc = is_sub ? ~nib_v[4] : nib_v[4];
                rsp_nxt.flags.n = arith_v[15];
                rsp_nxt.flags.ov = arith_ov;
                rsp_nxt.flags.z = (arith_v[15:0] == 16'h0000);
                rsp_nxt.upd = 8'h1F;
            end
            cise_pkg::CISE_LOOP_LIT, cise_pkg::CISE_LOOP_REG: begin              // see [RULE7]
                rsp_nxt.loop_cnt = (op == cise_pkg::CISE_LOOP_LIT) ? a[cise_pkg::CISE_LOOP_W-1:0]
                                                                    : b[cise_pkg::CISE_LOOP_W-1:0]; // see [RULE8]
                rsp_nxt.loop_end = req.ext;
            end
            cise_pkg::CISE_SQR, cise_pkg::CISE_SQR_ACC: begin                    // see [RULE9]
                rsp_nxt.acc = acc_v;
                rsp_nxt.flags.oa = (op == cise_pkg::CISE_SQR_ACC) & acc_ovf;
                rsp_nxt.flags.sa = (op == cise_pkg::CISE_SQR_ACC) & acc_ovf;
                rsp_nxt.res = b;
                rsp_nxt.res2 = req.ext;
                rsp_nxt.upd = 8'h60;
            end
            cise_pkg::CISE_SWAP: begin                                            // see [RULE14]
                rsp_nxt.res = b;
                rsp_nxt.res2 = a;
            end
            cise_pkg::CISE_BIT_CHG, cise_pkg::CISE_LEAD_ONE, cise_pkg::CISE_TRAIL_ONE: begin
                rsp_nxt.res = {10'h000, (op == cise_pkg::CISE_BIT_CHG) ? bit_chg_v :      // see [RULE10]
                               (op == cise_pkg::CISE_LEAD_ONE) ? lead_one_v : trail_one_v}; // see [RULE11]
                rsp_nxt.flags.c = (rsp_nxt.res[5:0] == cise_pkg::CISE_NO_BIT);         // see [RULE12]
                rsp_nxt.upd = 8'h01;
            end
            cise_pkg::CISE_JUMP:  rsp_nxt.jump_pc = {req.ext[7:0], a};               // see [RULE13]
            cise_pkg::CISE_OR: begin                                                 // see [RULE17]
                rsp_nxt.res = or_v;
                rsp_nxt.flags.n = or_v[15];
                rsp_nxt.flags.z = (or_v == 16'h0000);
                rsp_nxt.upd = 8'h14;
            end
            default: rsp_nxt.res = '0;
        endcase
    end

    // *****************************************************************
    // sequencing: busy counts down the documented cycle count
    // *****************************************************************
    wire logic start = req_valid & ~busy;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0; done <= 1'b0; cnt_r <= '0; op_r <= cise_pkg::CISE_NOP;
            rem_r <= '0; quo_r <= '0; dsr_r <= '0; neg_q_r <= 1'b0; neg_r_r <= 1'b0;
            ovf_hi_r <= 1'b0;
            pend_r <= '0; rsp <= '0; hold_r <= '0; irq_block <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            // interrupt hold-off counts instruction cycles down
            if (start && op == cise_pkg::CISE_HOLD_OFF) begin
                hold_r <= a[cise_pkg::CISE_HOLD_W-1:0];                             // see [RULE3]
                irq_block <= (a[cise_pkg::CISE_HOLD_W-1:0] != '0);
            end else if (hold_r != '0) begin
                hold_r <= hold_r - 14'h0001;
                irq_block <= (hold_r != 14'h0001);
            end
            if (start) begin
                op_r <= op; pend_r <= rsp_nxt;
                // high word preloads the remainder so sixteen steps suffice;
                // if it already reaches the divisor the quotient cannot fit
                rem_r <= {16'h0000, dvd_abs[31:16]};
                quo_r <= {dvd_abs[15:0], 16'h0000};
                ovf_hi_r <= (dvd_abs[31:16] >= dsr_abs);
                dsr_r <= dsr_abs;
                neg_q_r <= dvd_neg ^ dsr_neg; neg_r_r <= dvd_neg;
                cnt_r <= total_cyc - 5'h01;
                if (total_cyc == cise_pkg::CISE_CYC_ONE) begin
                    done <= 1'b1; rsp <= rsp_nxt;
                end else begin
                    busy <= 1'b1;
                end
            end else if (busy) begin
                cnt_r <= cnt_r - 5'h01;
                if (div_op_r && cnt_r <= div_steps + 5'h01
                    && cnt_r > 5'h01) begin                                         // see [RULE4]
                    rem_r <= rem_step;
                    quo_r <= quo_step;
                end
                if (cnt_r == 5'h01) begin
                    busy <= 1'b0; done <= 1'b1;
                    rsp <= pend_r;
                    if (div_op_r) begin                                             // see [RULE5]
                        rsp.res <= q_fin;
                        rsp.res2 <= r_fin;
                        rsp.flags.c <= (dsr_r != 16'h0000) & (rem_r[15:0] == 16'h0000);
                        rsp.flags.n <= q_fin[15];
                        rsp.flags.z <= (q_fin == 16'h0000);
                        rsp.flags.ov <= q_ovf;                                     // see [RULE6]
                        rsp.upd <= 8'h1D;
                    end
                end
            end
        end
    end
endmodule

// ===== test/cise_exec_asserts.sv
// concurrent checks for the instruction-subset execution unit
`timescale 1ns/1ps
module cise_exec_asserts (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                clk_en,
    input wire logic                req_valid,
    input wire cise_pkg::cise_req_t req,
    input wire logic [39:0]         acc_in,
    input wire logic                busy,
    input wire logic                done,
    input wire cise_pkg::cise_rsp_t rsp,
    input wire logic                irq_block
);
    // ****************************************************************
    // request decode
    // ****************************************************************
    wire logic take = req_valid && !busy && clk_en;
    wire logic fast = take && !req.sfr_ext;
    wire logic is_div = req.op inside {cise_pkg::CISE_DIV_S, cise_pkg::CISE_DIV_SD,
        cise_pkg::CISE_DIV_U, cise_pkg::CISE_DIV_UD, cise_pkg::CISE_DIV_F};
    wire logic is_two = req.op inside {cise_pkg::CISE_BANK_SW, cise_pkg::CISE_LOOP_LIT,
        cise_pkg::CISE_LOOP_REG};
    wire logic is_find = req.op inside {cise_pkg::CISE_BIT_CHG, cise_pkg::CISE_LEAD_ONE,
        cise_pkg::CISE_TRAIL_ONE};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // timing and flag checks
    // ****************************************************************
    property p_div_time;
        fast && is_div |-> ##18 done && rsp.upd == 8'h1D;
    endproperty
    property p_div_busy;
        fast && is_div |=> busy [*8];
    endproperty
    property p_two_cyc;
        fast && is_two |=> !done ##1 (done && rsp.upd == 8'h00);
    endproperty
    property p_jump;
        fast && req.op == cise_pkg::CISE_JUMP |=> !done [*3] ##1 (done && rsp.upd == 8'h00);
    endproperty
    property p_sfr;
        take && req.sfr_ext && req.op == cise_pkg::CISE_OR |=> !done ##1 done;
    endproperty
    property p_or;
        fast && req.op == cise_pkg::CISE_OR |=> done && rsp.upd == 8'h14
            && rsp.res == ($past(req.a) | $past(req.b));
    endproperty
    property p_inc;
        fast && req.op == cise_pkg::CISE_INC1 |=> done && rsp.upd == 8'h1F
            && rsp.res == $past(req.a) + 16'h0001;
    endproperty
    property p_find;
        fast && is_find |=> done && rsp.upd == 8'h01;
    endproperty
    property p_sqr;
        fast && req.op inside {cise_pkg::CISE_SQR, cise_pkg::CISE_SQR_ACC} |=> done
            && rsp.upd == 8'h60;
    endproperty
    property p_swap;
        fast && req.op == cise_pkg::CISE_SWAP |=> done && rsp.upd == 8'h00;
    endproperty

    a_div_time: assert property (p_div_time)
        else $error("divide timing wrong");
    a_div_busy: assert property (p_div_busy)
        else $error("busy low in divide");
    a_two_cyc: assert property (p_two_cyc)
        else $error("two-cycle op wrong");
    a_jump: assert property (p_jump)
        else $error("jump timing wrong");
    a_sfr: assert property (p_sfr)
        else $error("extra cycle missing");
    a_or: assert property (p_or)
        else $error("or result wrong");
    a_inc: assert property (p_inc)
        else $error("increment wrong");
    a_find: assert property (p_find)
        else $error("search flags wrong");
    a_sqr: assert property (p_sqr)
        else $error("square flags wrong");
    a_swap: assert property (p_swap)
        else $error("swap wrong");

    c_div: cover property (fast && is_div ##18 done);
    c_jump: cover property (fast && req.op == cise_pkg::CISE_JUMP ##4 done);
    c_hold: cover property (irq_block);
endmodule

bind cise_exec cise_exec_asserts u_chk (.clk, .sys_rst, .clk_en, .req_valid, .req, .acc_in,
    .busy, .done, .rsp, .irq_block);

// ===== test/testbench.sv
// self-checking bench for the instruction-subset execution unit
`timescale 1ns/1ps
module testbench;
    logic                clk;
    logic                sys_rst;
    logic                clk_en;
    logic                req_valid;
    cise_pkg::cise_req_t req;
    logic [39:0]         acc_in;
    logic                busy;
    logic                done;
    cise_pkg::cise_rsp_t rsp;
    logic                irq_block;
    int                  fail_count;
    int                  checked;
    int                  n;

    cise_exec u_cise_exec (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
        .req(req), .acc_in(acc_in), .busy(busy), .done(done), .rsp(rsp), .irq_block(irq_block));

    always #5 clk = ~clk;

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one request, then count edges until done; a hung op ends the run
    task automatic run_op(input cise_pkg::cise_op_t op, input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] ext, input logic sfr);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, a, b, ext, sfr};
        @(posedge clk);
        req_valid <= 1'b0;
        // done stands one cycle only, so it is looked at just after each edge
        n = 1;
        #1;
        while (done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_arith(input cise_pkg::cise_op_t op, input logic [15:0] a, input logic [15:0] r);
        run_op(op, a, 16'h0000, 16'h0000, 1'b0);
        check(64'(n), 64'h1);
        check({rsp.res, rsp.upd}, {r, 8'h1F});
    endtask

    task automatic t_div(input cise_pkg::cise_op_t op, input logic [15:0] a, input logic [15:0] x,
        input logic [15:0] b, input logic [15:0] q, input logic [15:0] r);
        run_op(op, a, b, x, 1'b0);
        check(64'(n), 64'h12);
        check({rsp.res, rsp.res2, rsp.upd}, {q, r, 8'h1D});
    endtask

    // payload: bank, loop count, jump target, swapped partner
    task automatic t_plain(input cise_pkg::cise_op_t op, input logic [15:0] a, input logic [3:0] c,
        input logic [57:0] pay);
        logic [57:0] got;
        run_op(op, a, 16'h0005, 16'h0010, 1'b0);
        got = {rsp.bank, rsp.loop_cnt, rsp.jump_pc, rsp.res2};
        check(64'(n), 64'(c));
        check(64'(rsp.upd), 64'h0);
        check(64'(got), 64'(pay));
    endtask

    task automatic t_find(input cise_pkg::cise_op_t op, input logic [15:0] a, input logic [15:0] p,
        input logic c);
        run_op(op, a, 16'h0000, 16'h0000, 1'b0);
        check(64'(n), 64'h1);
        check({rsp.res, rsp.flags.c, rsp.upd}, {p, c, 8'h01});
    endtask

    task automatic t_misc();
        run_op(cise_pkg::CISE_BCD_ADJ, 16'h009A, 16'h0000, 16'h0000, 1'b0);
        check(64'(n), 64'h1);
        check({rsp.res, rsp.flags.c, rsp.upd}, {16'h0000, 1'b1, 8'h01});
        run_op(cise_pkg::CISE_OR, 16'h0F00, 16'h00F0, 16'h0000, 1'b1);
        check(64'(n), 64'h2);
        check({rsp.res, rsp.upd}, {16'h0FF0, 8'h14});
        run_op(cise_pkg::CISE_DIV_U, 16'h0007, 16'h0000, 16'h0000, 1'b0);
        check(64'(rsp.flags.ov), 64'h1);
        run_op(cise_pkg::CISE_SQR, 16'h0003, 16'h0000, 16'h0000, 1'b0);
        check(64'(n), 64'h1);
        check({rsp.acc, rsp.upd}, {40'h00_0000_0009, 8'h60});
        run_op(cise_pkg::CISE_SQR_ACC, 16'h0003, 16'h0000, 16'h0000, 1'b0);
        check(64'(n), 64'h1);
        check(64'(rsp.acc), 64'(40'h00_0000_0019));
    endtask

    // blocking should last exactly the literal count of cycles from done
    task automatic t_hold();
        run_op(cise_pkg::CISE_HOLD_OFF, 16'h0004, 16'h0000, 16'h0000, 1'b0);
        n = 0;
        while (irq_block === 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
            #1;
        end
        check(64'(n), 64'h4);
    endtask

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        req_valid = 1'b0;
        req = '0;
        acc_in = 40'h00_0000_0010;
        fail_count = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check({busy, done, irq_block}, 3'h0);
        check(64'(rsp == '0), 64'h1);
        t_arith(cise_pkg::CISE_INC1, 16'hFFFF, 16'h0000);
        t_arith(cise_pkg::CISE_ADD_TWO, 16'hFFFF, 16'h0001);
        t_arith(cise_pkg::CISE_DEC1, 16'h0000, 16'hFFFF);
        t_arith(cise_pkg::CISE_SUBTRACT_TWO, 16'h0001, 16'hFFFF);
        t_div(cise_pkg::CISE_DIV_S, 16'hFFF9, 16'h0000, 16'h0002, 16'hFFFD, 16'hFFFF);
        t_div(cise_pkg::CISE_DIV_SD, 16'hFFF9, 16'hFFFF, 16'h0002, 16'hFFFD, 16'hFFFF);
        t_div(cise_pkg::CISE_DIV_U, 16'h0007, 16'h0000, 16'h0002, 16'h0003, 16'h0001);
        t_div(cise_pkg::CISE_DIV_UD, 16'h0000, 16'h0001, 16'h0100, 16'h0100, 16'h0000);
        t_div(cise_pkg::CISE_DIV_F, 16'h1000, 16'h0000, 16'h4000, 16'h4000, 16'h0000);
        t_plain(cise_pkg::CISE_BANK_SW, 16'h0005, 4'h2,
            {3'h5, 15'h0000, 24'h000000, 16'h0000});
        t_plain(cise_pkg::CISE_LOOP_LIT, 16'h7FFF, 4'h2,
            {3'h0, 15'h7FFF, 24'h000000, 16'h0000});
        t_plain(cise_pkg::CISE_LOOP_REG, 16'h0003, 4'h2,
            {3'h0, 15'h0005, 24'h000000, 16'h0000});
        t_plain(cise_pkg::CISE_JUMP, 16'h0100, 4'h4,
            {3'h0, 15'h0000, 24'h100100, 16'h0000});
        t_plain(cise_pkg::CISE_SWAP, 16'h1234, 4'h1,
            {3'h0, 15'h0000, 24'h000000, 16'h1234});
        t_find(cise_pkg::CISE_LEAD_ONE, 16'h1000, 16'h0004, 1'b0);
        t_find(cise_pkg::CISE_LEAD_ONE, 16'h0000, 16'h0000, 1'b1);
        t_find(cise_pkg::CISE_TRAIL_ONE, 16'h8000, 16'h0010, 1'b0);
        t_find(cise_pkg::CISE_BIT_CHG, 16'hF000, 16'h0005, 1'b0);
        t_find(cise_pkg::CISE_BIT_CHG, 16'hFFFF, 16'h0000, 1'b1);
        t_misc();
        t_hold();
        final_report();
    end
endmodule
